//--- core/clock_select_alarm_control_pkg.sv
// Contract
// - reset pin low clears all
// - reset: defaults, outputs off
// - invalid pins report inputs one-three
// - invalid pins: enable, shared polarity
// - irq pin: maskable, own polarity
// - alarm-out mode: combined alarm
// - irq pin tristates otherwise
// - register select; pins tristate
// - auto: pins show three/four active
// - active pins: enable, polarity
// - align pin realigns frame sync
// - missing-pulse alarm, all inputs
// - offset alarm against input two
// - manual, revertive, non-revertive
// - hold uses aged history
// - fifteen-bit fine phase word
// - coarse phase steps
// - bypass passes input through
// - fifth output as frame sync
// - unlock pin: enable, polarity, status
package clock_select_alarm_control_pkg;

    localparam int CLK_MHZ = 100;

    // ********
    // timing
    // ********
    localparam int         LOS_TIME_NS     = 2000;
    localparam logic [7:0] LOS_CYCLES      = 8'((LOS_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam int         HIST_TIME_NS    = 10000;
    localparam logic [9:0] HIST_CYCLES     = 10'((HIST_TIME_NS * CLK_MHZ) / 1000);
    localparam int         HIST_DEPTH      = 4;
    localparam int         FOS_WINDOW      = 64;
    localparam int         FOS_THRESH_S3   = 1;
    localparam int         FOS_THRESH_SMC  = 4;
    localparam logic [7:0] FOS_WIN_LAST    = 8'(FOS_WINDOW - 1);
    localparam logic [7:0] FOS_S3_HI       = 8'(FOS_WINDOW + FOS_THRESH_S3);
    localparam logic [7:0] FOS_S3_LO       = 8'(FOS_WINDOW - FOS_THRESH_S3);
    localparam logic [7:0] FOS_SMC_HI      = 8'(FOS_WINDOW + FOS_THRESH_SMC);
    localparam logic [7:0] FOS_SMC_LO      = 8'(FOS_WINDOW - FOS_THRESH_SMC);
    localparam int         FINE_STEP_PS    = 3;
    localparam int         FINE_RANGE_PS   = 110;
    localparam int         COARSE_STEP_PS  = 200;

    // ********
    // register map
    // ********
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PINCFG = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [7:0] OFF_PHASE  = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_FLAGS  = 8'h14;

    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_PINSEL    = 2;
    localparam int CTRL_REGSEL    = 3;
    localparam int CTRL_OUT_EN    = 5;
    localparam int CTRL_BYPASS    = 6;
    localparam int CTRL_FSYNC_CFG = 7;
    localparam int CTRL_ALIGN_EN  = 8;
    localparam int CTRL_FOS_SMC   = 9;
    localparam int CTRL_W         = 10;

    localparam int PC_BAD_EN  = 0;
    localparam int PC_BAD_POL = 3;
    localparam int PC_IRQ_EN  = 4;
    localparam int PC_IRQ_POL = 5;
    localparam int PC_ALM_EN  = 6;
    localparam int PC_ACT_EN  = 7;
    localparam int PC_ACT_POL = 11;
    localparam int PC_LOL_EN  = 12;
    localparam int PC_UNLOCK_POLARITY = 13;
    localparam int PC_W       = 14;

    localparam int PH_INC = 16;
    localparam int PH_DEC = 17;
    localparam int FINE_W = 15;

    localparam int FLAG_LOS    = 0;
    localparam int FLAG_FOS    = 4;
    localparam int FLAG_UNLOCK = 8;
    localparam int FLAG_HOLD   = 9;
    localparam int FLAG_W      = 10;

    localparam int ST_ACTIVE = 8;
    localparam int ST_UNLOCK = 12;
    localparam int ST_HOLD   = 13;

    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [PC_W-1:0]   PC_RST   = 14'h0000;
    localparam logic [FLAG_W-1:0] MASK_RST = 10'h000;
    localparam logic [FINE_W-1:0] FINE_RST = 15'h0000;

    typedef enum logic [1:0] {
        MODE_MANUAL      = 2'b00,
        MODE_REVERTIVE   = 2'b01,
        MODE_NONREVERT   = 2'b10
    } sel_mode_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic level;
        logic oe;
    } pin_drive_type;

endpackage

//--- core/clock_select_alarm_control.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module clock_select_alarm_control
    import clock_select_alarm_control_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          srst,
    input  wire apb_req_type   apb_req,
    output apb_rsp_type        apb_rsp,
    input  wire logic          rst_n_pin,
    input  wire logic          input_clock_one,
    input  wire logic          input_clock_two,
    input  wire logic          input_clock_three,
    input  wire logic          input_clock_four,
    input  wire logic          pll_locked_pin,
    input  wire logic          frame_align_pin,
    input  wire logic [15:0]   freq_word,
    input  wire logic          select0_active3_pin_in,
    input  wire logic          select1_active4_pin_in,
    output pin_drive_type      select0_active3_pin,
    output pin_drive_type      select1_active4_pin,
    output pin_drive_type      input1_invalid_pin,
    output pin_drive_type      input2_invalid_pin,
    output pin_drive_type      input3_invalid_pin,
    output pin_drive_type      irq_alarm_pin,
    output pin_drive_type      input1_active_pin,
    output pin_drive_type      input2_active_pin,
    output pin_drive_type      input3_active_pin,
    output pin_drive_type      input4_active_pin,
    output pin_drive_type      unlock_pin,
    output logic               clock_output_enable,
    output logic               bypass_enable,
    output logic               frame_sync_output,
    output logic               frame_realign,
    output logic [FINE_W-1:0]  fine_phase_word,
    output logic               coarse_phase_inc,
    output logic               coarse_phase_dec,
    output logic               holdover_active,
    output logic [15:0]        holdover_word,
    output logic [1:0]         active_input
);

    // ********
    // pin synchronisers
    // ********
    localparam int SYN_W = 9;

    logic [SYN_W-1:0] syn_a_r;
    logic [SYN_W-1:0] syn_b_r;
    logic [3:0]       clk_prev_r;
    logic [3:0]       clk_s;
    logic [3:0]       clk_edge;
    logic             rst_n_s;
    logic [1:0]       sel_pin_s;
    logic             align_s;
    logic             locked_s;
    logic             rst;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            syn_a_r    <= '0;
            syn_b_r    <= '0;
            clk_prev_r <= '0;
        end else begin
            syn_a_r    <= {pll_locked_pin, frame_align_pin, select1_active4_pin_in,
                           select0_active3_pin_in, rst_n_pin, input_clock_four,
                           input_clock_three, input_clock_two, input_clock_one};
            syn_b_r    <= syn_a_r;
            clk_prev_r <= clk_s;
        end
    end

    assign clk_s     = syn_b_r[3:0];
    assign clk_edge  = clk_s & ~clk_prev_r;
    assign rst_n_s   = syn_b_r[4];
    assign sel_pin_s = syn_b_r[6:5];
    assign align_s   = syn_b_r[7];
    assign locked_s  = syn_b_r[8];
    // pin reset lasts while its synced level is low
    assign rst       = srst | ~rst_n_s;

    // ********
    // registers
    // ********
    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic [PC_W-1:0]   pc_r;
    logic [PC_W-1:0]   pc_nxt;
    logic [FLAG_W-1:0] mask_r;
    logic [FLAG_W-1:0] mask_nxt;
    logic [FLAG_W-1:0] flags_r;
    logic [FLAG_W-1:0] flags_nxt;
    logic [FLAG_W-1:0] flag_set;
    logic [FINE_W-1:0] fine_r;
    logic [FINE_W-1:0] fine_nxt;
    logic              inc_r;
    logic              inc_nxt;
    logic              dec_r;
    logic              dec_nxt;
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              pslverr_r;
    logic              pslverr_nxt;
    logic [31:0]       status;
    logic              wr_en;
    logic              setup;
    logic              mapped;

    logic [3:0]        los_r;
    logic [3:0]        fos_r;
    logic [3:0]        alarm;
    logic [1:0]        act_r;
    logic              hold_r;
    logic [3:0]        act_onehot;

    assign setup  = apb_req.psel & ~apb_req.penable;
    assign wr_en  = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign mapped = apb_req.paddr inside {OFF_CTRL, OFF_PINCFG, OFF_MASK, OFF_PHASE, OFF_STATUS, OFF_FLAGS};

    always_comb begin
        status = '0;
        status[FLAG_LOS +: 4]   = los_r;
        status[FLAG_FOS +: 4]   = fos_r;
        status[ST_ACTIVE +: 4]  = act_onehot;
        status[ST_UNLOCK]       = ~locked_s;
        status[ST_HOLD]         = hold_r;
    end

    always_comb begin
        ctrl_nxt    = ctrl_r;
        pc_nxt      = pc_r;
        mask_nxt    = mask_r;
        fine_nxt    = fine_r;
        inc_nxt     = 1'b0;
        dec_nxt     = 1'b0;
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        flags_nxt   = flags_r;
        if (wr_en) begin
            unique case (apb_req.paddr)
                OFF_CTRL:   ctrl_nxt  = apb_req.pwdata[CTRL_W-1:0];
                OFF_PINCFG: pc_nxt    = apb_req.pwdata[PC_W-1:0];
                OFF_MASK:   mask_nxt  = apb_req.pwdata[FLAG_W-1:0];
                OFF_PHASE: begin
                    fine_nxt = apb_req.pwdata[FINE_W-1:0];
                    inc_nxt  = apb_req.pwdata[PH_INC];
                    dec_nxt  = apb_req.pwdata[PH_DEC];
                end
                OFF_FLAGS:  flags_nxt = flags_r & ~apb_req.pwdata[FLAG_W-1:0];
                default:    flags_nxt = flags_r;
            endcase
        end
        // set beats clear
        flags_nxt = flags_nxt | flag_set;
        if (setup) begin
            pslverr_nxt = ~mapped;
            unique case (apb_req.paddr)
                OFF_CTRL:   prdata_nxt = 32'(ctrl_r);
                OFF_PINCFG: prdata_nxt = 32'(pc_r);
                OFF_MASK:   prdata_nxt = 32'(mask_r);
                OFF_PHASE:  prdata_nxt = 32'(fine_r);
                OFF_STATUS: prdata_nxt = status;
                OFF_FLAGS:  prdata_nxt = 32'(flags_r);
                default:    prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r    <= CTRL_RST;
            pc_r      <= PC_RST;
            mask_r    <= MASK_RST;
            fine_r    <= FINE_RST;
            flags_r   <= '0;
            inc_r     <= 1'b0;
            dec_r     <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            pc_r      <= pc_nxt;
            mask_r    <= mask_nxt;
            fine_r    <= fine_nxt;
            flags_r   <= flags_nxt;
            inc_r     <= inc_nxt;
            dec_r     <= dec_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign apb_rsp.prdata  = prdata_r;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = pslverr_r & apb_req.psel & apb_req.penable;

    // ********
    // input monitors
    // ********
    logic [7:0] ref_cnt_r;
    logic [7:0] ref_cnt_nxt;
    logic       win_end;

    // input two is the reference; window = fixed edge count
    assign win_end = clk_edge[1] && (ref_cnt_r == FOS_WIN_LAST);

    always_comb begin
        ref_cnt_nxt = ref_cnt_r;
        if (clk_edge[1]) begin
            ref_cnt_nxt = win_end ? 8'h00 : ref_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_cnt_r <= '0;
        end else begin
            ref_cnt_r <= ref_cnt_nxt;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mon
            logic [7:0] los_cnt_r;
            logic [7:0] los_cnt_nxt;
            logic [7:0] fos_cnt_r;
            logic [7:0] fos_cnt_nxt;
            logic       fos_nxt;
            logic       fos_hit;

            always_comb begin
                los_cnt_nxt = los_cnt_r;
                if (clk_edge[gi]) begin
                    los_cnt_nxt = 8'h00;
                end else if (los_cnt_r != LOS_CYCLES) begin
                    los_cnt_nxt = los_cnt_r + 8'h01;
                end
                fos_cnt_nxt = fos_cnt_r;
                if (win_end) begin
                    fos_cnt_nxt = {7'h00, clk_edge[gi]};
                end else if (clk_edge[gi] && fos_cnt_r != 8'hFF) begin
                    fos_cnt_nxt = fos_cnt_r + 8'h01;
                end
                if (ctrl_r[CTRL_FOS_SMC]) begin
                    fos_hit = (fos_cnt_r > FOS_SMC_HI) || (fos_cnt_r < FOS_SMC_LO);
                end else begin
                    fos_hit = (fos_cnt_r > FOS_S3_HI) || (fos_cnt_r < FOS_S3_LO);
                end
                fos_nxt = fos_r[gi];
                if (win_end) begin
                    fos_nxt = (gi != 1) && fos_hit;
                end
            end

            always_ff @(posedge core_clk) begin
                if (rst) begin
                    los_cnt_r  <= '0;
                    fos_cnt_r  <= '0;
                    los_r[gi]  <= 1'b0;
                    fos_r[gi]  <= 1'b0;
                end else begin
                    los_cnt_r  <= los_cnt_nxt;
                    fos_cnt_r  <= fos_cnt_nxt;
                    los_r[gi]  <= (los_cnt_nxt == LOS_CYCLES);
                    fos_r[gi]  <= fos_nxt;
                end
            end
        end
    endgenerate

    assign alarm = los_r | fos_r;

    // ********
    // input selection and digital hold
    // ********
    function automatic logic [2:0] first_healthy(input logic [3:0] bad);
        logic [2:0] res;
        res = 3'b000;
        for (int k = 3; k >= 0; k--) begin
            if (!bad[k]) begin
                res = {1'b1, 2'(k)};
            end
        end
        return res;
    endfunction

    logic [1:0]                 act_nxt;
    logic                       hold_nxt;
    logic [2:0]                 pick;
    logic                       locked_d_r;
    logic                       hold_d_r;
    logic [3:0]                 los_d_r;
    logic [3:0]                 fos_d_r;
    logic [HIST_DEPTH-1:0][15:0] hist_r;
    logic [HIST_DEPTH-1:0][15:0] hist_nxt;
    logic [9:0]                 hist_cnt_r;
    logic [9:0]                 hist_cnt_nxt;
    logic [15:0]                hold_word_r;
    logic [15:0]                hold_word_nxt;
    logic                       realign_nxt;
    logic                       realign_r;

    always_comb begin
        pick     = first_healthy(alarm);
        act_nxt  = act_r;
        hold_nxt = 1'b0;
        unique case (ctrl_r[CTRL_MODE_LSB +: 2])
            MODE_REVERTIVE: begin
                act_nxt  = pick[2] ? pick[1:0] : act_r;
                hold_nxt = ~pick[2];
            end
            MODE_NONREVERT: begin
                if (alarm[act_r]) begin
                    act_nxt  = pick[2] ? pick[1:0] : act_r;
                    hold_nxt = ~pick[2];
                end
            end
            default: begin
                if (ctrl_r[CTRL_PINSEL]) begin
                    act_nxt = sel_pin_s;
                end else begin
                    act_nxt = ctrl_r[CTRL_REGSEL +: 2];
                end
                hold_nxt = alarm[act_nxt];
            end
        endcase
    end

    // history freezes in hold so the aged value stays clean
    always_comb begin
        hist_nxt      = hist_r;
        hist_cnt_nxt  = hist_cnt_r;
        hold_word_nxt = hold_word_r;
        if (!hold_r) begin
            hold_word_nxt = hist_r[HIST_DEPTH-1];
            if (hist_cnt_r == HIST_CYCLES - 10'd1) begin
                hist_cnt_nxt = 10'd0;
                hist_nxt     = {hist_r[HIST_DEPTH-2:0], freq_word};
            end else begin
                hist_cnt_nxt = hist_cnt_r + 10'd1;
            end
        end
        // sync input: three for one/three, four for two/four
        realign_nxt = ctrl_r[CTRL_ALIGN_EN] & ctrl_r[CTRL_FSYNC_CFG] & align_s
                      & clk_edge[{1'b1, act_r[0]}];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            act_r       <= 2'b00;
            hold_r      <= 1'b0;
            hist_r      <= '0;
            hist_cnt_r  <= '0;
            hold_word_r <= '0;
            realign_r   <= 1'b0;
            locked_d_r  <= 1'b1;
            hold_d_r    <= 1'b0;
            los_d_r     <= '0;
            fos_d_r     <= '0;
        end else begin
            act_r       <= act_nxt;
            hold_r      <= hold_nxt;
            hist_r      <= hist_nxt;
            hist_cnt_r  <= hist_cnt_nxt;
            hold_word_r <= hold_word_nxt;
            realign_r   <= realign_nxt;
            locked_d_r  <= locked_s;
            hold_d_r    <= hold_r;
            los_d_r     <= los_r;
            fos_d_r     <= fos_r;
        end
    end

    always_comb begin
        act_onehot        = 4'h0;
        act_onehot[act_r] = 1'b1;
        flag_set                   = '0;
        flag_set[FLAG_LOS +: 4]    = los_r & ~los_d_r;
        flag_set[FLAG_FOS +: 4]    = fos_r & ~fos_d_r;
        flag_set[FLAG_UNLOCK]      = locked_d_r & ~locked_s;
        flag_set[FLAG_HOLD]        = hold_r & ~hold_d_r;
    end

    // ********
    // pin drivers
    // ********
    localparam int NPIN = 11;

    pin_drive_type [NPIN-1:0] pin_r;
    pin_drive_type [NPIN-1:0] pin_nxt;
    logic                     irq_act;
    logic                     auto_mode;

    assign irq_act   = |(flags_r & mask_r);
    assign auto_mode = ctrl_r[CTRL_MODE_LSB +: 2] inside {MODE_REVERTIVE, MODE_NONREVERT};

    always_comb begin
        pin_nxt = '0;
        for (int k = 0; k < 3; k++) begin
            pin_nxt[k].level = ~(alarm[k] ^ pc_r[PC_BAD_POL]);
            pin_nxt[k].oe    = pc_r[PC_BAD_EN + k];
        end
        if (pc_r[PC_IRQ_EN]) begin
            pin_nxt[3].level = ~(irq_act ^ pc_r[PC_IRQ_POL]);
            pin_nxt[3].oe    = 1'b1;
        end else if (pc_r[PC_ALM_EN]) begin
            pin_nxt[3].level = ~((|alarm) ^ pc_r[PC_BAD_POL]);
            pin_nxt[3].oe    = 1'b1;
        end else begin
            pin_nxt[3].oe    = 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            pin_nxt[4 + k].level = ~(act_onehot[k] ^ pc_r[PC_ACT_POL]);
            pin_nxt[4 + k].oe    = pc_r[PC_ACT_EN + k];
        end
        pin_nxt[8].level  = ~(~locked_s ^ pc_r[PC_UNLOCK_POLARITY]);
        pin_nxt[8].oe     = pc_r[PC_LOL_EN];
        // manual mode: select pins stay host-driven inputs
        pin_nxt[9].level  = act_onehot[2];
        pin_nxt[9].oe     = auto_mode;
        pin_nxt[10].level = act_onehot[3];
        pin_nxt[10].oe    = auto_mode;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_r <= '0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    assign input1_invalid_pin  = pin_r[0];
    assign input2_invalid_pin  = pin_r[1];
    assign input3_invalid_pin  = pin_r[2];
    assign irq_alarm_pin       = pin_r[3];
    assign input1_active_pin   = pin_r[4];
    assign input2_active_pin   = pin_r[5];
    assign input3_active_pin   = pin_r[6];
    assign input4_active_pin   = pin_r[7];
    assign unlock_pin          = pin_r[8];
    assign select0_active3_pin = pin_r[9];
    assign select1_active4_pin = pin_r[10];

    // ********
    // core controls
    // ********
    // outputs stay off after reset until re-enabled
    assign clock_output_enable = ctrl_r[CTRL_OUT_EN];
    assign bypass_enable       = ctrl_r[CTRL_OUT_EN] & ctrl_r[CTRL_BYPASS];
    assign frame_sync_output   = ctrl_r[CTRL_OUT_EN] & ctrl_r[CTRL_FSYNC_CFG];
    assign frame_realign       = realign_r;
    assign fine_phase_word     = fine_r;
    assign coarse_phase_inc    = inc_r;
    assign coarse_phase_dec    = dec_r;
    assign holdover_active     = hold_r;
    assign holdover_word       = hold_word_r;
    assign active_input        = act_r;

endmodule

//--- sim/clock_select_alarm_control_properties.sv
`timescale 1ns/1ns
module clock_select_alarm_control_properties
    import clock_select_alarm_control_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          srst,
    input wire apb_req_type   apb_req,
    input wire logic          rst_n_pin,
    input wire logic          pll_locked_pin,
    input wire logic          select0_active3_pin_in,
    input wire logic          select1_active4_pin_in,
    input wire pin_drive_type select0_active3_pin,
    input wire pin_drive_type input1_invalid_pin,
    input wire pin_drive_type irq_alarm_pin,
    input wire pin_drive_type unlock_pin,
    input wire logic          clock_output_enable,
    input wire logic [1:0]    active_input
);
    logic [CTRL_W-1:0] ctrl_r;
    logic [PC_W-1:0]   pc_r;
    logic [2:0]        quiet_r;
    logic              wr;
    logic              st;
    logic              man;
    assign wr  = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign st  = &quiet_r;
    assign man = st && ctrl_r[1:0] == 2'h0;
    // config mirror; quiet_r lets pins settle after a write
    always_ff @(posedge core_clk) begin
        if (srst || !rst_n_pin) begin
            ctrl_r  <= '0;
            pc_r    <= '0;
            quiet_r <= 3'h0;
        end else begin
            if (wr && apb_req.paddr == OFF_CTRL) ctrl_r <= apb_req.pwdata[CTRL_W-1:0];
            if (wr && apb_req.paddr == OFF_PINCFG) pc_r <= apb_req.pwdata[PC_W-1:0];
            quiet_r <= wr ? 3'h0 : {quiet_r[1:0], 1'b1};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst || !rst_n_pin);
    property p_bad_oe; st |-> input1_invalid_pin.oe == pc_r[PC_BAD_EN]; endproperty
    a_bad_oe: assert property (p_bad_oe) else $error("bad oe");
    property p_irq_oe; st |-> irq_alarm_pin.oe == (pc_r[PC_IRQ_EN] || pc_r[PC_ALM_EN]); endproperty
    a_irq_oe: assert property (p_irq_oe) else $error("irq oe");
    property p_lol_oe; st |-> unlock_pin.oe == pc_r[PC_LOL_EN]; endproperty
    a_lol_oe: assert property (p_lol_oe) else $error("lol oe");
    property p_lol_lvl; (st && $stable(pll_locked_pin))[*5] |->
        !unlock_pin.oe || unlock_pin.level == (!pll_locked_pin ~^ pc_r[PC_UNLOCK_POLARITY]); endproperty
    a_lol_lvl: assert property (p_lol_lvl) else $error("lol level");
    property p_sel_oe; st |-> select0_active3_pin.oe == (ctrl_r[1:0] == 2'h1 || ctrl_r[1:0] == 2'h2); endproperty
    a_sel_oe: assert property (p_sel_oe) else $error("sel oe");
    property p_sel_man; (man && ctrl_r[CTRL_PINSEL] && $stable({select1_active4_pin_in, select0_active3_pin_in}))[*6]
        |-> active_input == {select1_active4_pin_in, select0_active3_pin_in}; endproperty
    a_sel_man: assert property (p_sel_man) else $error("pin select");
    property p_reg_sel; man && !ctrl_r[CTRL_PINSEL] |-> active_input == ctrl_r[4:3]; endproperty
    a_reg_sel: assert property (p_reg_sel) else $error("reg select");
    property p_rst; $fell(srst) |-> !clock_output_enable && !irq_alarm_pin.oe; endproperty
    a_rst: assert property (p_rst) else $error("reset out");
endmodule

//--- sim/clock_source_model.sv
`timescale 1ns/1ns
module clock_source_model
    import clock_select_alarm_control_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic [3:0]    run,
    input  wire logic [1:0]    host_sel,
    input  wire pin_drive_type sel0_drv,
    input  wire pin_drive_type sel1_drv,
    output logic [3:0]         ck,
    output logic [1:0]         sel_in
);
    logic [2:0] div_r = 3'h0;
    initial ck = 4'h0;
    // a stopped source rests low
    always @(posedge core_clk) begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'h7) ck <= ~ck & run;
    end
    assign sel_in = {sel1_drv.oe ? sel1_drv.level : host_sel[1], sel0_drv.oe ? sel0_drv.level : host_sel[0]};
endmodule

//--- sim/clock_select_alarm_control_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %0t %0h %0h", $time, g, e); end end
module clock_select_alarm_control_tb;
    import clock_select_alarm_control_pkg::*;
    logic          core_clk = 1'b0;
    logic          srst = 1'b1;
    logic          rst_n_pin = 1'b1;
    logic          pll_locked_pin = 1'b0;
    logic [3:0]    run = 4'hF;
    logic [1:0]    hsel = 2'h0;
    logic [3:0]    ck;
    logic [1:0]    sel_in;
    logic          oen;
    logic [1:0]    active_input;
    logic [31:0]   rd;
    logic          err;
    apb_req_type   apb_req = '0;
    apb_rsp_type   apb_rsp;
    pin_drive_type sel0, sel1, bad1, irq, act4, pll_unlock_flag;
    int            err_total = 0;
    int            checks = 0;
    always #5 core_clk = ~core_clk;
    clock_source_model i_clock_source_model (.core_clk, .run, .host_sel(hsel), .sel0_drv(sel0), .sel1_drv(sel1),
        .ck, .sel_in);
    clock_select_alarm_control i_clock_select_alarm_control (.core_clk, .srst, .apb_req, .apb_rsp, .rst_n_pin,
        .input_clock_one(ck[0]), .input_clock_two(ck[1]), .input_clock_three(ck[2]), .input_clock_four(ck[3]),
        .pll_locked_pin, .frame_align_pin(1'b0), .freq_word(16'h1234), .select0_active3_pin_in(sel_in[0]),
        .select1_active4_pin_in(sel_in[1]), .select0_active3_pin(sel0), .select1_active4_pin(sel1),
        .input1_invalid_pin(bad1), .input2_invalid_pin(), .input3_invalid_pin(), .irq_alarm_pin(irq),
        .input1_active_pin(), .input2_active_pin(), .input3_active_pin(), .input4_active_pin(act4),
        .unlock_pin(pll_unlock_flag), .clock_output_enable(oen), .bypass_enable(), .frame_sync_output(), .frame_realign(),
        .fine_phase_word(), .coarse_phase_inc(), .coarse_phase_dec(), .holdover_active(), .holdover_word(),
        .active_input);
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        if (n == 20) give_verdict(1);
    endtask
    task automatic give_verdict(input int fail);
        err_total += fail;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic t_reset();
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK({rd, oen}, 33'h0)
        apb(1'b1, OFF_CTRL, 32'h20);
        rst_n_pin <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK({rd, oen}, 33'h0)
        apb(1'b0, 8'h18, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        $display("reset done");
    endtask
    task automatic t_pins();
        logic [13:0] cfg [3] = '{14'h3C11, 14'h0040, 14'h0000};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFF_PINCFG, 32'(cfg[i]));
            repeat (4) @(posedge core_clk);
            `CHK(irq.oe, i < 2)
            `CHK(bad1.oe, i == 0)
            `CHK({act4.oe, act4.level & act4.oe}, {i == 0, 1'b0})
            `CHK({pll_unlock_flag.oe, pll_unlock_flag.level & pll_unlock_flag.oe}, {i == 0, i == 0})
        end
        $display("pins done");
    endtask
    task automatic t_manual();
        apb(1'b1, OFF_CTRL, 32'h4);
        for (int i = 0; i < 4; i++) begin
            hsel <= 2'(i);
            repeat (8) @(posedge core_clk);
            `CHK(active_input, 2'(i))
        end
        apb(1'b1, OFF_CTRL, 32'h10);
        repeat (4) @(posedge core_clk);
        `CHK({sel0.oe, active_input}, 3'h2)
        $display("manual done");
    endtask
    task automatic t_auto(input logic [1:0] mode, input logic [1:0] back);
        apb(1'b1, OFF_CTRL, 32'(mode));
        repeat (1500) @(posedge core_clk);
        `CHK({sel0.oe, sel0.level, active_input}, 4'h8)
        run <= 4'hE;
        repeat (400) @(posedge core_clk);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK({rd[0], active_input}, 3'h5)
        run <= 4'hF;
        repeat (2200) @(posedge core_clk);
        `CHK(active_input, back)
        $display("auto done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_pins();
        t_manual();
        t_auto(MODE_REVERTIVE, 2'h0);
        t_auto(MODE_NONREVERT, 2'h1);
        give_verdict(0);
    end
endmodule
bind clock_select_alarm_control clock_select_alarm_control_properties i_props (.*);
